// File: src/matrix_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef MATRIX_REGS_SVH
`define MATRIX_REGS_SVH

`define CONFIG_OFS 8'h00
`define SHUTDOWN_OFS 8'h0A
`define FUNC_LAST_OFS 8'h0C
`define FUNC_COUNT 13
`define PAGE_SEL_OFS 8'hFD
`define PAGE_FUNC 8'h0B
`define FRAME_COUNT 8
`define FRAME_BYTES 11'h0B4
`define FRAME_LAST_OFS 8'hB3
`define FUNC_RESET 8'h00
`define PAGE_RESET 8'h00
`define SYNC_SEL_HI 7
`define SYNC_SEL_LO 6
`define SSD_HI 1
`define SSD_LO 0
`define SLAVE_ADDR 7'h74
`define REF_CLK_PERIOD_NS 16'h000A
`define SYNC_CLK_PERIOD_NS 16'h00A0
`define SYNC_HALF_CYC (8'((`SYNC_CLK_PERIOD_NS / 16'h0002) / `REF_CLK_PERIOD_NS))

`endif

// File: src/matrix_pkg.sv
// Types and decode helpers shared by the shutdown and serial port logic
package matrix_pkg;

  typedef enum logic [1:0] {
    SSD_SOFT1,
    SSD_NORMAL,
    SSD_SOFT2
  } ssd_mode_e;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_PTR,
    ST_WRITE,
    ST_READ
  } serial_state_e;

  function automatic ssd_mode_e decode_shutdown(input logic [1:0] sel);
    ssd_mode_e m;
    m = SSD_SOFT2;
    if (sel == 2'h0) begin
      m = SSD_SOFT1;
    end else if (sel == 2'h1) begin
      m = SSD_NORMAL;
    end
    return m;
  endfunction

endpackage

// File: src/sync_if.sv
// Link between the register logic and the cascade clock unit
`timescale 1ns/10ps
interface sync_if;
  logic [1:0] sync_sel;
  logic tick;
  modport ctrl (output sync_sel, input tick);
  modport unit (input sync_sel, output tick);
endinterface

// File: src/sync_clock_unit.sv
// Cascade clock master divider and slave edge follower
`timescale 1ns/10ps
`include "matrix_regs.svh"
module sync_clock_unit
  import matrix_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  sync_if.unit bus,
  input wire logic sync_i,
  output logic sync_o,
  output logic sync_oe_n
);

  typedef struct packed {
    logic [7:0] div;
    logic clk_out;
    logic in_s1;
    logic in_s2;
    logic in_s3;
    logic tick;
  } unit_s;

  unit_s r_reg;
  unit_s r_next;

  always_comb begin
    r_next = r_reg;
    r_next.in_s1 = sync_i;
    r_next.in_s2 = r_reg.in_s1;
    r_next.in_s3 = r_reg.in_s2;
    r_next.tick = 1'b0;
    unique case (bus.sync_sel)
      2'h1: begin
        // Master: one tick per rising edge of the driven clock
        if (r_reg.div == `SYNC_HALF_CYC - 8'h01) begin
          r_next.div = 8'h00;
          r_next.clk_out = ~r_reg.clk_out;
          r_next.tick = ~r_reg.clk_out;
        end else begin
          r_next.div = r_reg.div + 8'h01;
        end
      end
      2'h2: begin
        // Slave: timing follows the master's rising edges
        r_next.div = 8'h00;
        r_next.clk_out = 1'b0;
        r_next.tick = r_reg.in_s2 & ~r_reg.in_s3;
      end
      default: begin
        r_next.div = 8'h00;
        r_next.clk_out = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign sync_o = r_reg.clk_out;
  assign sync_oe_n = ~(bus.sync_sel == 2'h1);
  assign bus.tick = r_reg.tick;

endmodule

// File: src/matrix_driver_shutdown_sync_ctrl.sv
// Serial register port, shutdown control and frame memory of the matrix driver
`timescale 1ns/10ps
`include "matrix_regs.svh"
module matrix_driver_shutdown_sync_ctrl
  import matrix_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic shutdown_pin_n,
  input wire logic sync_i,
  output logic sync_o,
  output logic sync_oe_n,
  output logic sync_tick,
  output logic analog_enable,
  output logic current_enable,
  output logic matrix_blank,
  output logic [7:0] config_out
);

  typedef struct packed {
    serial_state_e st;
    logic [3:0] bitcnt;
    logic [7:0] sr;
    logic [7:0] ptr;
    logic [7:0] page;
    logic [7:0] txbyte;
    logic sda_drv;
    logic scl_s1;
    logic scl_s2;
    logic scl_s3;
    logic sda_s1;
    logic sda_s2;
    logic sda_s3;
    logic sdb_s1;
    logic sdb_s2;
    logic drive_en;
    logic [`FUNC_COUNT-1:0][7:0] func;
  } ctrl_s;

  ctrl_s r_reg;
  ctrl_s r_next;

  // No reset on purpose: contents stay undefined until written
  logic [7:0] frame_mem [0:`FRAME_COUNT*180-1];
  logic mem_we;
  logic [10:0] mem_wa;
  logic [7:0] mem_wd;

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic frame_locked;
  logic frame_page;
  logic func_hit;
  logic frame_hit;
  logic [7:0] rd_data;

  function automatic logic [10:0] frame_index(input logic [2:0] pg, input logic [7:0] ofs);
    return 11'(pg) * `FRAME_BYTES + 11'(ofs);
  endfunction

  sync_if sbus ();

  sync_clock_unit u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .bus(sbus.unit),
    .sync_i(sync_i),
    .sync_o(sync_o),
    .sync_oe_n(sync_oe_n)
  );

  assign sbus.sync_sel = r_reg.func[`CONFIG_OFS][`SYNC_SEL_HI:`SYNC_SEL_LO];

  // Edges are taken from the second and third stages only
  assign scl_rise = r_reg.scl_s2 & ~r_reg.scl_s3;
  assign scl_fall = ~r_reg.scl_s2 & r_reg.scl_s3;
  assign start_seen = r_reg.scl_s2 & r_reg.scl_s3 & ~r_reg.sda_s2 & r_reg.sda_s3;
  assign stop_seen = r_reg.scl_s2 & r_reg.scl_s3 & r_reg.sda_s2 & ~r_reg.sda_s3;

  // Frame page shut off by the pin or by software shutdown 2
  assign frame_locked = ~r_reg.sdb_s2 |
    (decode_shutdown(r_reg.func[`SHUTDOWN_OFS][`SSD_HI:`SSD_LO]) == SSD_SOFT2);
  assign frame_page = (r_reg.page[7:3] == 5'h00);
  assign func_hit = (r_reg.page == `PAGE_FUNC) && (r_reg.ptr <= `FUNC_LAST_OFS);
  assign frame_hit = frame_page && (r_reg.ptr <= `FRAME_LAST_OFS) && !frame_locked;

  always_comb begin
    rd_data = 8'h00;
    if (r_reg.ptr == `PAGE_SEL_OFS) begin
      rd_data = r_reg.page;
    end else if (func_hit) begin
      rd_data = r_reg.func[r_reg.ptr[3:0]];
    end else if (frame_hit) begin
      rd_data = frame_mem[frame_index(r_reg.page[2:0], r_reg.ptr)];
    end
  end

  always_comb begin
    r_next = r_reg;
    mem_we = 1'b0;
    mem_wa = frame_index(r_reg.page[2:0], r_reg.ptr);
    mem_wd = r_reg.sr;
    r_next.scl_s1 = scl_i;
    r_next.scl_s2 = r_reg.scl_s1;
    r_next.scl_s3 = r_reg.scl_s2;
    r_next.sda_s1 = sda_i;
    r_next.sda_s2 = r_reg.sda_s1;
    r_next.sda_s3 = r_reg.sda_s2;
    // The pin only gates activity; no register is touched by it
    r_next.sdb_s1 = shutdown_pin_n;
    r_next.sdb_s2 = r_reg.sdb_s1;
    // Sources run only in normal mode with the pin high
    r_next.drive_en = r_reg.sdb_s2 &&
      (decode_shutdown(r_reg.func[`SHUTDOWN_OFS][`SSD_HI:`SSD_LO]) == SSD_NORMAL);
    if (start_seen) begin
      r_next.st = ST_ADDR;
      r_next.bitcnt = 4'h0;
      r_next.sda_drv = 1'b0;
    end else if (stop_seen) begin
      r_next.st = ST_IDLE;
      r_next.sda_drv = 1'b0;
    end else if (r_reg.st != ST_IDLE && scl_rise) begin
      if (r_reg.bitcnt < 4'h8) begin
        r_next.sr = {r_reg.sr[6:0], r_reg.sda_s2};
        r_next.bitcnt = r_reg.bitcnt + 4'h1;
      end else begin
        r_next.bitcnt = 4'h9;
        // Own address ack is not a host ack; only count after a data byte
        if (r_reg.st == ST_READ && !r_reg.sda_drv) begin
          if (r_reg.sda_s2) begin
            r_next.st = ST_IDLE;
          end else begin
            r_next.ptr = r_reg.ptr + 8'h01;
          end
        end
      end
    end else if (r_reg.st != ST_IDLE && scl_fall) begin
      if (r_reg.bitcnt == 4'h8) begin
        r_next.sda_drv = 1'b0;
        unique case (r_reg.st)
          ST_ADDR: begin
            // A read aimed at a locked frame page is not acknowledged
            if (r_reg.sr[7:1] == `SLAVE_ADDR && !(r_reg.sr[0] && frame_page && frame_locked)) begin
              r_next.sda_drv = 1'b1;
              r_next.st = r_reg.sr[0] ? ST_READ : ST_PTR;
            end else begin
              r_next.st = ST_IDLE;
            end
          end
          ST_PTR: begin
            r_next.ptr = r_reg.sr;
            r_next.sda_drv = 1'b1;
            r_next.st = ST_WRITE;
          end
          ST_WRITE: begin
            if (r_reg.ptr == `PAGE_SEL_OFS) begin
              r_next.page = r_reg.sr;
              r_next.sda_drv = 1'b1;
            end else if (func_hit) begin
              r_next.func[r_reg.ptr[3:0]] = r_reg.sr;
              r_next.sda_drv = 1'b1;
            end else if (frame_hit) begin
              mem_we = 1'b1;
              r_next.sda_drv = 1'b1;
            end
            // Refused bytes are not acknowledged, pointer still advances
            r_next.ptr = r_reg.ptr + 8'h01;
          end
          ST_READ: begin
            r_next.sda_drv = 1'b0;
          end
          ST_IDLE: begin
          end
        endcase
      end else if (r_reg.bitcnt == 4'h9) begin
        r_next.bitcnt = 4'h0;
        r_next.sda_drv = 1'b0;
        if (r_reg.st == ST_READ) begin
          r_next.txbyte = rd_data;
          r_next.sda_drv = ~rd_data[7];
        end
      end else if (r_reg.st == ST_READ && r_reg.bitcnt != 4'h0) begin
        r_next.sda_drv = ~r_reg.txbyte[3'h7 - r_reg.bitcnt[2:0]];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
      r_reg.st <= ST_IDLE;
      r_reg.page <= `PAGE_RESET;
      r_reg.func <= {`FUNC_COUNT{`FUNC_RESET}};
      r_reg.scl_s1 <= 1'b1;
      r_reg.scl_s2 <= 1'b1;
      r_reg.scl_s3 <= 1'b1;
      r_reg.sda_s1 <= 1'b1;
      r_reg.sda_s2 <= 1'b1;
      r_reg.sda_s3 <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      frame_mem[mem_wa] <= mem_wd;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_n = ~r_reg.sda_drv;
  assign sync_tick = sbus.tick;
  assign analog_enable = r_reg.sdb_s2;
  assign current_enable = r_reg.drive_en;
  assign matrix_blank = ~r_reg.drive_en;
  assign config_out = r_reg.func[`CONFIG_OFS];

endmodule

// File: test/matrix_chk.sv
// Port checks of cascade clock, shutdown and reset behaviour
`timescale 1ns/10ps
module matrix_chk (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic shutdown_pin_n,
  input wire logic sync_i,
  input wire logic sync_o,
  input wire logic sync_oe_n,
  input wire logic sync_tick,
  input wire logic analog_enable,
  input wire logic current_enable,
  input wire logic matrix_blank,
  input wire logic [7:0] config_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [1:0] sel;
  assign sel = config_out[7:6];
  property p_moe;
    (sel == 2'b01) [*2] |-> !sync_oe_n;
  endproperty
  a_moe: assert property (p_moe) else $error("master pin not driven");
  property p_mtick;
    sel == 2'b01 && $rose(sync_o) |-> ##[0:1] sync_tick;
  endproperty
  a_mtick: assert property (p_mtick) else $error("master tick missing");
  // Leaving master mode may cut a high phase short
  property p_mper;
    $rose(sync_o) |-> (sync_o [*8] ##1 !sync_o) or (##[1:9] sel != 2'b01);
  endproperty
  a_mper: assert property (p_mper) else $error("master period wrong");
  property p_stick;
    (sel == 2'b10) [*2] ##0 $rose(sync_i) |-> ##[2:5] sync_tick;
  endproperty
  a_stick: assert property (p_stick) else $error("slave tick missing");
  property p_rel;
    (sel != 2'b01) [*2] |-> sync_oe_n;
  endproperty
  a_rel: assert property (p_rel) else $error("cascade pin not released");
  property p_quiet;
    (sel == 2'b00 || sel == 2'b11) [*8] |-> !sync_tick;
  endproperty
  a_quiet: assert property (p_quiet) else $error("tick while sync off");
  property p_blank;
    (!analog_enable [*2] |-> !current_enable) and (matrix_blank != current_enable);
  endproperty
  a_blank: assert property (p_blank) else $error("blank and sources disagree");
  property p_hw;
    $stable(shutdown_pin_n) [*4] |-> analog_enable == shutdown_pin_n;
  endproperty
  a_hw: assert property (p_hw) else $error("analog enable ignores pin");
  property p_keep;
    $changed(shutdown_pin_n) |-> $stable(config_out) [*3];
  endproperty
  a_keep: assert property (p_keep) else $error("pin changed a register");
  property p_rst;
    $rose(rst_n) |-> config_out == 8'h00 && sync_oe_n;
  endproperty
  a_rst: assert property (p_rst) else $error("reset value wrong");
  c_master: cover property (sync_tick && !sync_oe_n);
  c_slave: cover property (sel == 2'b10 && sync_tick);
  c_hwsd: cover property (!shutdown_pin_n && !analog_enable);
endmodule
bind matrix_driver_shutdown_sync_ctrl matrix_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .shutdown_pin_n(shutdown_pin_n), .sync_i(sync_i), .sync_o(sync_o), .sync_oe_n(sync_oe_n),
  .sync_tick(sync_tick), .analog_enable(analog_enable), .current_enable(current_enable),
  .matrix_blank(matrix_blank), .config_out(config_out));

// File: test/host_model.sv
// Serial bus host: drives clock and data, senses the shared wire
`timescale 1ns/10ps
module host_model (
  input wire logic ref_clk,
  input wire logic sda_in,
  output logic scl,
  output logic sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic hw(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Data moves only while clock is low, so no false start or stop
  task automatic bit1(input logic b, output logic r);
    hw(1);
    sda <= b;
    hw(5);
    scl <= 1'b1;
    hw(3);
    @(negedge ref_clk);
    r = sda_in;
    hw(2);
    scl <= 1'b0;
  endtask
  task automatic start();
    sda <= 1'b1;
    hw(4);
    scl <= 1'b1;
    hw(6);
    sda <= 1'b0;
    hw(6);
    scl <= 1'b0;
  endtask
  task automatic stop();
    hw(1);
    sda <= 1'b0;
    hw(5);
    scl <= 1'b1;
    hw(6);
    sda <= 1'b1;
    hw(6);
  endtask
  task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit1(d[i], q[i]);
    end
    bit1(ai, a);
  endtask
endmodule

// File: test/tb_top.sv
// Bench: register access, shutdown levels and cascade clock modes
`timescale 1ns/10ps
module tb_top;
  logic ref_clk, rst_n, shutdown_pin_n, sync_i, lk, scl, host_sda, sda_w, sda_o, sda_oe_n;
  logic sync_o, sync_oe_n, sync_tick, analog_enable, current_enable, matrix_blank;
  logic [7:0] config_out;
  int num_errors, checked, cyc, ticks, n;
  // Pull-up data wire; cascade pin follows whoever drives it
  assign sda_w = host_sda & (sda_oe_n | sda_o);
  assign sync_i = sync_oe_n ? lk : sync_o;
  host_model host (.ref_clk(ref_clk), .sda_in(sda_w), .scl(scl), .sda(host_sda));
  matrix_driver_shutdown_sync_ctrl dut (.ref_clk(ref_clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .shutdown_pin_n(shutdown_pin_n), .sync_i(sync_i), .sync_o(sync_o),
    .sync_oe_n(sync_oe_n), .sync_tick(sync_tick), .analog_enable(analog_enable),
    .current_enable(current_enable), .matrix_blank(matrix_blank), .config_out(config_out));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    lk = 1'b0;
    #3;
    forever #80 lk = ~lk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (sync_tick === 1'b1) ticks <= ticks + 1;
    if (cyc == 60000) begin
      num_errors = num_errors + 1;
      finish_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks=%0d errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d, input logic ok);
    logic [7:0] q;
    logic a0, a1, a2;
    host.start();
    host.xfer(8'hE8, 1'b1, q, a0);
    host.xfer(p, 1'b1, q, a1);
    host.xfer(d, 1'b1, q, a2);
    host.stop();
    chk({5'h00, a0, a1, a2}, {5'h00, 2'b00, ~ok});
  endtask
  task automatic rd(input logic [7:0] p, input logic [7:0] e, input logic ok);
    logic [7:0] q;
    logic a;
    host.start();
    host.xfer(8'hE8, 1'b1, q, a);
    host.xfer(p, 1'b1, q, a);
    host.stop();
    host.start();
    host.xfer(8'hE9, 1'b1, q, a);
    chk({7'h00, a}, {7'h00, ~ok});
    if (ok) begin
      host.xfer(8'hFF, 1'b1, q, a);
      chk(q, e);
    end
    host.stop();
  endtask
  task automatic t_reset();
    chk(config_out, 8'h00);
    chk({7'h00, sync_oe_n}, 8'h01);
    wr(8'hFD, 8'h0B, 1'b1);
    rd(8'h0A, 8'h00, 1'b1);
    rd(8'h20, 8'h00, 1'b1);
    wr(8'h20, 8'h12, 1'b0);
  endtask
  task automatic t_sync();
    logic [7:0] m [4] = '{8'h40, 8'h80, 8'hC0, 8'h00};
    logic [7:0] e [4] = '{8'h0A, 8'h14, 8'h00, 8'h00};
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, m[i], 1'b1);
      n = ticks;
      host.hw(320);
      chk(8'(ticks - n), e[i] + (i == 0 ? 8'h0A : 8'h00));
      chk({7'h00, sync_oe_n}, {7'h00, i != 0});
    end
  endtask
  task automatic t_ssd();
    wr(8'h00, 8'h15, 1'b1);
    for (int s = 0; s < 4; s++) begin
      wr(8'hFD, 8'h0B, 1'b1);
      wr(8'h0A, 8'(s), 1'b1);
      host.hw(4);
      chk({6'h00, current_enable, matrix_blank}, {6'h00, s == 1, s != 1});
      wr(8'hFD, 8'h00, 1'b1);
      wr(8'h10, 8'hA0 + 8'(s), s < 2);
      rd(8'h10, 8'hA0 + 8'(s), s < 2);
    end
    wr(8'hFD, 8'h0B, 1'b1);
    rd(8'h00, 8'h15, 1'b1);
    wr(8'h0A, 8'h01, 1'b1);
    wr(8'hFD, 8'h00, 1'b1);
    rd(8'h10, 8'hA1, 1'b1);
  endtask
  task automatic t_hw();
    // Pin toggles from its idle high level
    shutdown_pin_n <= ~shutdown_pin_n;
    host.hw(4);
    chk({7'h00, analog_enable}, 8'h00);
    wr(8'h10, 8'h77, 1'b0);
    rd(8'h10, 8'h00, 1'b0);
    wr(8'hFD, 8'h0B, 1'b1);
    rd(8'h00, 8'h15, 1'b1);
    wr(8'h00, 8'h15, 1'b1);
    rd(8'h0A, 8'h01, 1'b1);
    shutdown_pin_n <= ~shutdown_pin_n;
    host.hw(4);
    chk({7'h00, analog_enable}, 8'h01);
    for (int p = 4; p < 8; p++) begin
      wr(8'hFD, 8'(p), 1'b1);
      wr(8'h11, 8'(p), 1'b1);
      rd(8'h11, 8'(p), 1'b1);
    end
    wr(8'hFD, 8'h00, 1'b1);
    rd(8'h10, 8'hA1, 1'b1);
  endtask
  task automatic t_rst();
    wr(8'hFD, 8'h0B, 1'b1);
    wr(8'h00, 8'hC0, 1'b1);
    rst_n <= 1'b0;
    host.hw(2);
    chk(config_out, 8'h00);
    rst_n <= 1'b1;
    host.hw(3);
    wr(8'hFD, 8'h0B, 1'b1);
    rd(8'h0A, 8'h00, 1'b1);
  endtask
  initial begin
    rst_n = 1'b0;
    shutdown_pin_n = 1'b1;
    checked = 0;
    num_errors = 0;
    cyc = 0;
    ticks = 0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    host.hw(3);
    t_reset();
    t_sync();
    t_ssd();
    t_hw();
    t_rst();
    finish_test();
  end
endmodule
